// File: hw/stepper_pattern_generator.sv
// two-channel stepping motor control and pattern generation port
`timescale 1ns/10ps
module stepper_pattern_generator
  import stepper_pattern_pkg::*;
(
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst_n,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wr_data,
  input  wire logic              i_wr_en,
  input  wire logic              i_rd_en,
  output logic      [DATA_W-1:0] o_rd_data,
  input  wire logic [1:0]        i_timer_pair_mode,
  input  wire logic [WIDE_W-1:0] i_pair_counter,
  input  wire logic [7:0]        i_timer_low_compare,
  input  wire logic [7:0]        i_timer_cycle_compare,
  input  wire logic              i_flipflop_invert_enable,
  input  wire logic [WIDE_W-1:0] i_wide_counter_a,
  input  wire logic [WIDE_W-1:0] i_wide_timer_a_compare_b,
  input  wire logic              i_match_b_trigger_enable,
  input  wire logic              i_match_b_alt_trigger_enable,
  input  wire logic [WIDE_W-1:0] i_wide_counter_b,
  input  wire logic [WIDE_W-1:0] i_wide_timer_b_compare_b,
  input  wire logic              i_timer_b_match_trigger_enable,
  input  wire logic [PORT_W-1:0] i_port_function_select,
  input  wire logic [PORT_W-1:0] i_port_data,
  output logic      [PORT_W-1:0] o_port_pin
);

  // shift helpers: forward moves each phase one step toward the last
  function automatic logic [NIBBLE_W-1:0] rot4(
    input logic [NIBBLE_W-1:0] v,
    input logic                rev
  );
    rot4 = rev ? {v[0], v[NIBBLE_W-1:1]} : {v[NIBBLE_W-2:0], v[NIBBLE_W-1]};
  endfunction

  function automatic logic [RING_W-1:0] rot8(
    input logic [RING_W-1:0] v,
    input logic              rev
  );
    rot8 = rev ? {v[0], v[RING_W-1:1]} : {v[RING_W-2:0], v[RING_W-1]};
  endfunction

  // ring order from top: latch3 alt3 latch2 alt2 latch1 alt1 latch0 alt0
  function automatic logic [RING_W-1:0] ring_pack(
    input logic [NIBBLE_W-1:0] lat,
    input logic [NIBBLE_W-1:0] alt
  );
    logic [RING_W-1:0] r;
    r = '0;
    for (int i = 0; i < NIBBLE_W; i++)
    begin
      r[2*i+1] = lat[i];
      r[2*i]   = alt[i];
    end
    ring_pack = r;
  endfunction

  logic [DATA_W-1:0]   ctrl_ff;
  logic [DATA_W-1:0]   nxt_ctrl;
  logic [DATA_W-1:0]   rd_data_ff;
  logic [DATA_W-1:0]   nxt_rd_data;
  logic [PORT_W-1:0]   pin_ff;
  logic [PORT_W-1:0]   nxt_pin;
  logic [NUM_CHAN-1:0] trig_lvl;
  logic [NUM_CHAN-1:0] trig_lvl_ff;
  logic [NUM_CHAN-1:0] trig_pulse;
  logic [NUM_CHAN-1:0] chan_wr;
  logic [NIBBLE_W-1:0] latch_ff [NUM_CHAN];
  logic [NIBBLE_W-1:0] sa_ff    [NUM_CHAN];
  logic [PORT_W-1:0]   pattern;
  logic [WIDE_W-1:0]   pair_compare;

  assign pair_compare = {i_timer_cycle_compare, i_timer_low_compare};
  assign chan_wr[0]   = i_wr_en && (i_addr == PATTERN_CHANNEL0_REG_ADDR);
  assign chan_wr[1]   = i_wr_en && (i_addr == PATTERN_CHANNEL1_REG_ADDR);

  // trigger levels from the timers
  always_comb
  begin
    unique case (i_timer_pair_mode)
      TMODE_16BIT: trig_lvl[0] = (i_pair_counter == pair_compare);
      TMODE_PPG:   trig_lvl[0] =
                     (i_pair_counter[7:0] == i_timer_cycle_compare);
      default:     trig_lvl[0] = 1'b0;
    endcase
    if (!i_flipflop_invert_enable)
    begin
      trig_lvl[0] = 1'b0;
    end
    if (ctrl_ff[CTL_CHAN_W + CTL_SOURCE_BIT])
    begin
      trig_lvl[1] = (i_wide_counter_b == i_wide_timer_b_compare_b)
                    && i_timer_b_match_trigger_enable;
    end
    else
    begin
      trig_lvl[1] = (i_wide_counter_a == i_wide_timer_a_compare_b)
                    && (i_match_b_trigger_enable
                        || i_match_b_alt_trigger_enable);
    end
  end

  // rising edge of each level makes a single-cycle pulse
  assign trig_pulse = trig_lvl & ~trig_lvl_ff;

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      trig_lvl_ff <= '0;
    end
    else
    begin
      trig_lvl_ff <= trig_lvl;
    end
  end

  // per-channel pattern state
  generate
    for (genvar c = 0; c < NUM_CHAN; c++)
    begin : g_chan
      logic [NIBBLE_W-1:0] nxt_latch;
      logic [NIBBLE_W-1:0] nxt_sa;
      logic [RING_W-1:0]   ring;
      logic                mode_sel;
      logic                reverse;
      logic                excite12;

      assign mode_sel = ctrl_ff[c*CTL_CHAN_W + CTL_MODE_SEL_BIT];
      assign reverse  = ctrl_ff[c*CTL_CHAN_W + CTL_REVERSE_BIT];
      assign excite12 = ctrl_ff[c*CTL_CHAN_W + CTL_EXCITE12_BIT];

      always_comb
      begin
        nxt_latch = latch_ff[c];
        nxt_sa    = sa_ff[c];
        ring      = rot8(ring_pack(latch_ff[c], sa_ff[c]), reverse);
        if (trig_pulse[c])
        begin
          if (excite12 || mode_sel)
          begin
            for (int i = 0; i < NIBBLE_W; i++)
            begin
              nxt_latch[i] = ring[2*i+1];
              nxt_sa[i]    = ring[2*i];
            end
          end
          else
          begin
            nxt_latch = rot4(latch_ff[c], reverse);
          end
        end
        // a write in the same cycle as a shift overrides the shifted alternate value, and the latch too unless mode_sel is set
        if (chan_wr[c])
        begin
          nxt_sa = i_wr_data[SA_LSB +: NIBBLE_W];
          if (!mode_sel)
          begin
            nxt_latch = i_wr_data[LATCH_LSB +: NIBBLE_W];
          end
        end
      end

      always_ff @(posedge i_clk_sys or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          latch_ff[c] <= LATCH_RST;
          sa_ff[c]    <= SA_RST;
        end
        else
        begin
          latch_ff[c] <= nxt_latch;
          sa_ff[c]    <= nxt_sa;
        end
      end

      assign pattern[c*NIBBLE_W +: NIBBLE_W] = latch_ff[c];
    end
  endgenerate

  // pin multiplexer, one select bit per pin
  generate
    for (genvar p = 0; p < PORT_W; p++)
    begin : g_pin
      assign nxt_pin[p] = i_port_function_select[p] ? pattern[p]
                                                    : i_port_data[p];
    end
  endgenerate

  // register file
  always_comb
  begin
    nxt_ctrl    = ctrl_ff;
    nxt_rd_data = RD_RST;
    if (i_wr_en && (i_addr == PATTERN_CONTROL_REG_ADDR))
    begin
      nxt_ctrl = i_wr_data;
    end
    if (i_rd_en)
    begin
      unique case (i_addr)
        PATTERN_CHANNEL0_REG_ADDR: nxt_rd_data = {4'h0, sa_ff[0]};
        PATTERN_CHANNEL1_REG_ADDR: nxt_rd_data = {4'h0, sa_ff[1]};
        PATTERN_CONTROL_REG_ADDR:  nxt_rd_data = ctrl_ff;
        default:                   nxt_rd_data = RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ctrl_ff    <= CTRL_RST;
      rd_data_ff <= RD_RST;
      pin_ff     <= PIN_RST;
    end
    else
    begin
      ctrl_ff    <= nxt_ctrl;
      rd_data_ff <= nxt_rd_data;
      pin_ff     <= nxt_pin;
    end
  end

  assign o_rd_data  = rd_data_ff;
  assign o_port_pin = pin_ff;

  // checks on channel 0 behaviour, plus the channel 1 timer a trigger
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_shift0;
    trig_pulse[0] && !chan_wr[0];
  endsequence

  sequence s_step0_fwd;
    s_shift0 and (!ctrl_ff[CTL_REVERSE_BIT] && !ctrl_ff[CTL_EXCITE12_BIT]
      && !ctrl_ff[CTL_MODE_SEL_BIT]);
  endsequence

  sequence s_step0_rev;
    s_shift0 and (ctrl_ff[CTL_REVERSE_BIT] && !ctrl_ff[CTL_EXCITE12_BIT]
      && !ctrl_ff[CTL_MODE_SEL_BIT]);
  endsequence

  sequence s_ring0_fwd;
    s_shift0 and (!ctrl_ff[CTL_REVERSE_BIT]
      && (ctrl_ff[CTL_EXCITE12_BIT] || ctrl_ff[CTL_MODE_SEL_BIT]));
  endsequence

  AST_STEP_FWD: assert property (s_step0_fwd |=>
    latch_ff[0] == {$past(latch_ff[0][2:0]), $past(latch_ff[0][3])})
    else $error("forward step did not rotate toward last phase");

  AST_STEP_REV: assert property (s_step0_rev |=>
    latch_ff[0] == {$past(latch_ff[0][0]), $past(latch_ff[0][3:1])})
    else $error("reverse step did not rotate toward first phase");

  AST_ALT_IGNORED: assert property (s_step0_fwd or s_step0_rev |=>
    $stable(sa_ff[0]))
    else $error("alternate register moved in single-nibble mode");

  AST_RING_SHIFT: assert property (s_ring0_fwd |=>
    sa_ff[0][0] == $past(latch_ff[0][3])
    && latch_ff[0][0] == $past(sa_ff[0][0])
    && sa_ff[0][1] == $past(latch_ff[0][0]))
    else $error("one-two ring did not advance by one place");

  AST_LATCH_LOCKED: assert property (
    chan_wr[0] && ctrl_ff[CTL_MODE_SEL_BIT] && !trig_pulse[0]
    |=> $stable(latch_ff[0]))
    else $error("latch written in pattern generation mode");

  AST_ALT_WRITE: assert property (chan_wr[0] |=>
    sa_ff[0] == $past(i_wr_data[3:0]))
    else $error("alternate register did not take written value");

  AST_ONE_PULSE: assert property (trig_pulse[0] |=>
    !trig_pulse[0] [*1] ##0 trig_lvl_ff[0])
    else $error("trigger pulse longer than one cycle");

  AST_NO_TRIG: assert property (
    (i_timer_pair_mode == TMODE_PWM) || (i_timer_pair_mode == TMODE_8BIT)
    |-> !trig_pulse[0])
    else $error("trigger produced in PWM or 8-bit mode");

  AST_PIN_MUX: assert property (i_rst_n |=>
    o_port_pin[3:0] == (($past(i_port_function_select[3:0])
                         & $past(latch_ff[0]))
                        | (~$past(i_port_function_select[3:0])
                           & $past(i_port_data[3:0]))))
    else $error("pin does not follow its function select");

  AST_WIDE_A: assert property (
    !ctrl_ff[CTL_CHAN_W + CTL_SOURCE_BIT] && trig_pulse[1]
    |-> i_wide_counter_a == i_wide_timer_a_compare_b
        && (i_match_b_trigger_enable || i_match_b_alt_trigger_enable))
    else $error("channel 1 triggered without timer a match");

endmodule

// File: hw/stepper_pattern_pkg.sv
// constants for the stepping motor pattern generator
package stepper_pattern_pkg;

  localparam int NUM_CHAN = 2;
  localparam int NIBBLE_W = 4;
  localparam int PORT_W   = 8;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 8;
  localparam int RING_W   = 8;
  localparam int WIDE_W   = 16;

  // register map
  localparam logic [ADDR_W-1:0] PATTERN_CHANNEL0_REG_ADDR = 8'h4C;
  localparam logic [ADDR_W-1:0] PATTERN_CHANNEL1_REG_ADDR = 8'h4D;
  localparam logic [ADDR_W-1:0] PATTERN_CONTROL_REG_ADDR  = 8'h4E;

  // channel register layout
  localparam int LATCH_LSB = 4;
  localparam int SA_LSB    = 0;

  // control register: one nibble per channel, channel 0 in the low nibble
  localparam int CTL_CHAN_W       = 4;
  localparam int CTL_MODE_SEL_BIT = 0;
  localparam int CTL_REVERSE_BIT  = 1;
  localparam int CTL_EXCITE12_BIT = 2;
  localparam int CTL_SOURCE_BIT   = 3;

  // reset values
  localparam logic [NIBBLE_W-1:0] LATCH_RST = 4'h0;
  localparam logic [NIBBLE_W-1:0] SA_RST    = 4'h0;
  localparam logic [DATA_W-1:0]   CTRL_RST  = 8'h00;
  localparam logic [PORT_W-1:0]   PIN_RST   = 8'h00;
  localparam logic [DATA_W-1:0]   RD_RST    = 8'h00;
  localparam logic [DATA_W-1:0]   RD_UNMAPPED = 8'h00;

  // operating mode of the 8-bit timer pair feeding channel 0
  localparam logic [1:0] TMODE_8BIT  = 2'h0;
  localparam logic [1:0] TMODE_16BIT = 2'h1;
  localparam logic [1:0] TMODE_PPG   = 2'h2;
  localparam logic [1:0] TMODE_PWM   = 2'h3;

endpackage

// File: testbench/motor_driver_model.sv
// observer model of the motor driver stage on the port pins
`timescale 1ns/10ps
module motor_driver_model
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  input  wire logic [7:0] i_phase_pins,
  output logic      [7:0] o_step_count
);
  logic [7:0] last_pins_ff;

  // every change seen on the phase pins counts as one driver step
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      last_pins_ff <= 8'h00;
      o_step_count <= 8'h00;
    end
    else
    begin
      last_pins_ff <= i_phase_pins;
      if (i_phase_pins !== last_pins_ff)
        o_step_count <= o_step_count + 8'h01;
    end
  end
endmodule

// File: testbench/tb_stepper_pattern_generator.sv
// self-checking testbench of the stepping motor pattern generator
`timescale 1ns/10ps
module tb_stepper_pattern_generator
  import stepper_pattern_pkg::*;
;
  logic              i_clk_sys = 1'b0;
  logic              i_rst_n = 1'b0;
  logic [ADDR_W-1:0] i_addr = 8'h00;
  logic [DATA_W-1:0] i_wr_data = 8'h00;
  logic              i_wr_en = 1'b0;
  logic              i_rd_en = 1'b0;
  logic [DATA_W-1:0] o_rd_data;
  logic [1:0]        i_timer_pair_mode = TMODE_16BIT;
  logic [WIDE_W-1:0] i_pair_counter = 16'h0000;
  logic              i_flipflop_invert_enable = 1'b1;
  logic [WIDE_W-1:0] i_wide_counter_a = 16'h0000;
  logic              i_match_b_trigger_enable = 1'b1;
  logic              i_match_b_alt_trigger_enable = 1'b0;
  logic [WIDE_W-1:0] i_wide_counter_b = 16'h0000;
  logic              i_timer_b_match_trigger_enable = 1'b1;
  logic [PORT_W-1:0] i_port_function_select = 8'h0F;
  logic [PORT_W-1:0] i_port_data = 8'hA5;
  logic [PORT_W-1:0] o_port_pin;
  logic [7:0]        step_count;
  logic [1:0]        idle_modes [2] = '{TMODE_PWM, TMODE_8BIT};
  int                mismatches = 0;
  int                check_count = 0;

  localparam logic [7:0] CH0 = PATTERN_CHANNEL0_REG_ADDR;
  localparam logic [7:0] CH1 = PATTERN_CHANNEL1_REG_ADDR;
  localparam logic [7:0] CTL = PATTERN_CONTROL_REG_ADDR;

  always #50 i_clk_sys = ~i_clk_sys;

  stepper_pattern_generator dut
  (
    .i_clk_sys                      (i_clk_sys),
    .i_rst_n                        (i_rst_n),
    .i_addr                         (i_addr),
    .i_wr_data                      (i_wr_data),
    .i_wr_en                        (i_wr_en),
    .i_rd_en                        (i_rd_en),
    .o_rd_data                      (o_rd_data),
    .i_timer_pair_mode              (i_timer_pair_mode),
    .i_pair_counter                 (i_pair_counter),
    .i_timer_low_compare            (8'h34),
    .i_timer_cycle_compare          (8'h12),
    .i_flipflop_invert_enable       (i_flipflop_invert_enable),
    .i_wide_counter_a               (i_wide_counter_a),
    .i_wide_timer_a_compare_b       (16'h0100),
    .i_match_b_trigger_enable       (i_match_b_trigger_enable),
    .i_match_b_alt_trigger_enable   (i_match_b_alt_trigger_enable),
    .i_wide_counter_b               (i_wide_counter_b),
    .i_wide_timer_b_compare_b       (16'h0200),
    .i_timer_b_match_trigger_enable (i_timer_b_match_trigger_enable),
    .i_port_function_select         (i_port_function_select),
    .i_port_data                    (i_port_data),
    .o_port_pin                     (o_port_pin)
  );

  motor_driver_model driver
  (
    .i_clk_sys    (i_clk_sys),
    .i_rst_n      (i_rst_n),
    .i_phase_pins (o_port_pin),
    .o_step_count (step_count)
  );

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(posedge i_clk_sys);
    i_addr    <= a;
    i_wr_data <= d;
    i_wr_en   <= 1'b1;
    @(posedge i_clk_sys);
    i_wr_en   <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, exp);
    @(posedge i_clk_sys);
    i_addr  <= a;
    i_rd_en <= 1'b1;
    @(posedge i_clk_sys);
    i_rd_en <= 1'b0;
    #1;
    chk("read data", o_rd_data, exp);
  endtask

  // holds the given counter values for n cycles, then waits for the pins
  task automatic tk(input logic [15:0] pc, wa, wb, input int n);
    @(posedge i_clk_sys);
    i_pair_counter   <= pc;
    i_wide_counter_a <= wa;
    i_wide_counter_b <= wb;
    repeat (n) @(posedge i_clk_sys);
    i_pair_counter   <= 16'h0000;
    i_wide_counter_a <= 16'h0000;
    i_wide_counter_b <= 16'h0000;
    repeat (3) @(posedge i_clk_sys);
    #1;
  endtask

  initial
  begin
    repeat (2000) @(posedge i_clk_sys);
    mismatches++;
    stop_test;
  end

  initial
  begin
    repeat (4) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    rc(CH0, 8'h00);
    rc(CTL, CTRL_RST);
    rc(8'h50, RD_UNMAPPED);
    chk("pins", o_port_pin, 8'hA0);
    wr(CH0, 8'hC8);
    rc(CH0, 8'h08);
    chk("pins", o_port_pin, 8'hAC);
    tk(16'h1234, 16'h0000, 16'h0000, 1);
    chk("pins", o_port_pin, 8'hA9);
    rc(CH0, 8'h08);
    tk(16'h1234, 16'h0000, 16'h0000, 4);
    chk("pins", o_port_pin, 8'hA3);
    @(posedge i_clk_sys);
    i_port_function_select <= 8'hFF;
    wr(CH1, 8'h10);
    rc(CH1, 8'h00);
    tk(16'h0000, 16'h0100, 16'h0000, 1);
    chk("pins", o_port_pin, 8'h23);
    @(posedge i_clk_sys);
    i_match_b_trigger_enable     <= 1'b0;
    i_match_b_alt_trigger_enable <= 1'b1;
    tk(16'h0000, 16'h0100, 16'h0000, 1);
    chk("pins", o_port_pin, 8'h43);
    wr(CTL, 8'h80);
    tk(16'h0000, 16'h0000, 16'h0200, 1);
    chk("pins", o_port_pin, 8'h83);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge i_clk_sys);
      i_timer_pair_mode <= idle_modes[k];
      tk(16'h1234, 16'h0000, 16'h0000, 1);
      chk("pins", o_port_pin, 8'h83);
    end
    @(posedge i_clk_sys);
    i_timer_pair_mode <= TMODE_PPG;
    tk(16'h1234, 16'h0000, 16'h0000, 1);
    chk("pins", o_port_pin, 8'h83);
    tk(16'h0012, 16'h0000, 16'h0000, 1);
    chk("pins", o_port_pin, 8'h86);
    @(posedge i_clk_sys);
    i_flipflop_invert_enable <= 1'b0;
    tk(16'h0012, 16'h0000, 16'h0000, 1);
    chk("pins", o_port_pin, 8'h86);
    @(posedge i_clk_sys);
    i_flipflop_invert_enable <= 1'b1;
    wr(CTL, 8'h82);
    tk(16'h0012, 16'h0000, 16'h0000, 1);
    chk("pins", o_port_pin, 8'h83);
    wr(CTL, 8'h84);
    wr(CH0, 8'hC8);
    tk(16'h0012, 16'h0000, 16'h0000, 1);
    chk("pins", o_port_pin, 8'h88);
    rc(CH0, 8'h09);
    wr(CTL, 8'h86);
    tk(16'h0012, 16'h0000, 16'h0000, 1);
    chk("pins", o_port_pin, 8'h8C);
    rc(CH0, 8'h08);
    wr(CTL, 8'h81);
    wr(CH0, 8'h35);
    rc(CH0, 8'h05);
    chk("pins", o_port_pin, 8'h8C);
    tk(16'h0012, 16'h0000, 16'h0000, 1);
    chk("pins", o_port_pin, 8'h85);
    rc(CH0, 8'h09);
    wr(CTL, 8'h84);
    wr(CH0, 8'h37);
    tk(16'h0012, 16'h0000, 16'h0000, 1);
    chk("pins", o_port_pin, 8'h87);
    rc(CH0, 8'h06);
    chk("driver steps", step_count, 8'h11);
    stop_test;
  end
endmodule
